// ==== src/epsm_device.sv ====
// epsm_device: power state manager of the Ethernet controller (D0, D1 wake frame, D2 energy)
// assumes: host on epsm_if.dev, wake_frame_hit from rx logic on clk, line energy async
// Functional notes
// RULE_01: host reads only control register while asleep
// RULE_02: ready flag clear in either sleep state
// RULE_03: host writes only wake test while not ready
// RULE_04: writes ignored until first read after wake
// RULE_05: wake test write in sleep returns D0
// RULE_06: mode 01 enters D1, clears ready
// RULE_07: D1 stops MAC and host clocks only
// RULE_08: D1 detection sets wakeup source to 10
// RULE_09: D1 pin needs frame and pin enables
// RULE_10: interrupt status ignores the pin enable
// RULE_11: host sets energy powerdown, then mode 10
// RULE_12: D2 stops all clocks, PHY energy powerdown
// RULE_13: D2 carrier sets wakeup source to 01
// RULE_14: D2 pin needs energy and pin enables
// RULE_15: host clears energy powerdown after ready
// RULE_16: host clears wakeup source after ready
// RULE_17: interrupt status sticky while wake condition holds
// RULE_18: pulse select gives 50ms pulse, else level
// RULE_19: pin drops with source, enable or pin enable
// RULE_20: general powerdown bit holds PHY off, reset on clear
// RULE_21: energy powerdown follows line energy, sets flag
// RULE_22: ready set within 2ms of wake write
// RULE_23: D0 keeps ready; mode reads current state
`timescale 1ns/10ps
`include "epsm_regs.svh"
module epsm_device #(
	parameter int unsigned READY_CYC = `EPSM_READY_CYC,
	parameter int unsigned PULSE_CYC = `EPSM_PULSE_CYC
) (
	input  wire logic           clk,                 // system clock, 25 MHz
	input  wire logic           sys_rst,             // async reset, active high
	input  wire logic           ce,                  // clock enable, freezes all state
	epsm_if.dev                 bus,                 // host bus and wake pin
	input  wire logic           wake_frame_hit,      // wake frame or magic packet seen
	input  wire logic           line_energy_present, // line energy from the PHY, async
	output logic                mac_clk_en,          // MAC datapath clock enable
	output logic                host_clk_en,         // host interface clock enable
	output logic                int_clk_en,          // internal clock enable
	output logic                rx_pm_en,            // receive power-management logic on
	output logic                phy_power_off,       // PHY powered down
	output logic                phy_reset,           // one-cycle PHY reset
	output epsm_pkg::epsm_pstate_t power_state       // state in effect
);
	import epsm_pkg::*;

	epsm_pstate_t pstate_q, pstate_d;
	logic        ready_q, ready_d;
	logic        armed_q, armed_d;
	logic        pin_en_q, pin_en_d;
	logic        pulse_sel_q, pulse_sel_d;
	logic        energy_en_q, energy_en_d;
	logic        frame_en_q, frame_en_d;
	logic [1:0]  wus_q, wus_d;
	logic        int_q, int_d;
	logic        gen_pd_q, gen_pd_d;
	logic        energy_pd_q, energy_pd_d;
	logic        eflag_q, eflag_d;
	logic        phy_rst_q, phy_rst_d;
	logic [15:0] rdy_cnt_q, rdy_cnt_d;
	logic [15:0] rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;
	logic        pme_q, pme_d;
	logic        pin_cond_q, pin_cond_d;
	logic        energy_s1_q, energy_s2_q, energy_prev_q;
	logic        wr_ok, wake_wr, cond, pin_cond, pulse_on;
	logic [15:0] ctrl_rd;

	// wake condition and pin drive from the registered source and enables
	assign cond = (wus_q == `EPSM_WUS_FRAME && frame_en_q) ||
		(wus_q == `EPSM_WUS_ENERGY && energy_en_q); // RULE_17
	assign pin_cond = cond && pin_en_q; // RULE_09 RULE_14 RULE_19

	epsm_pulse_timer #(.CYC(PULSE_CYC)) u_pulse (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.start   (pin_cond && !pin_cond_q),
		.hold    (pin_cond),
		.active  (pulse_on)
	);

	always_comb begin
		ctrl_rd = 16'h0000;
		ctrl_rd[`EPSM_CTRL_READY] = ready_q;
		ctrl_rd[`EPSM_CTRL_PIN_EN] = pin_en_q;
		ctrl_rd[`EPSM_CTRL_PULSE_SEL] = pulse_sel_q;
		ctrl_rd[`EPSM_CTRL_ENERGY_EN] = energy_en_q;
		ctrl_rd[`EPSM_CTRL_FRAME_EN] = frame_en_q;
		ctrl_rd[`EPSM_CTRL_WUS_HI:`EPSM_CTRL_WUS_LO] = wus_q;
		ctrl_rd[`EPSM_CTRL_MODE_HI:`EPSM_CTRL_MODE_LO] = pstate_q; // RULE_23
	end

	always_comb begin
		pstate_d = pstate_q;
		ready_d = ready_q;
		armed_d = armed_q;
		pin_en_d = pin_en_q;
		pulse_sel_d = pulse_sel_q;
		energy_en_d = energy_en_q;
		frame_en_d = frame_en_q;
		wus_d = wus_q;
		gen_pd_d = gen_pd_q;
		energy_pd_d = energy_pd_q;
		eflag_d = eflag_q;
		rdy_cnt_d = rdy_cnt_q;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		wr_ok = bus.bus_wr && armed_q && ready_q && pstate_q == EPSM_D0; // RULE_03 RULE_04
		wake_wr = bus.bus_wr && bus.bus_addr == `EPSM_ADDR_WAKE_TEST && pstate_q != EPSM_D0;
		int_d = int_q;

		// reads: every read answers; control gives its value, the rest read zero unless awake and ready
		if (bus.bus_rd) begin
			rvalid_d = 1'b1;
			armed_d = 1'b1; // RULE_04
			rdata_d = 16'h0000;
			if (bus.bus_addr == `EPSM_ADDR_CTRL) begin
				rdata_d = ctrl_rd;
			end else if (ready_q && pstate_q == EPSM_D0) begin // RULE_01
				case (bus.bus_addr)
					`EPSM_ADDR_INTERRUPT_STATUS_REGISTER: rdata_d = {15'h0000, int_q};
					`EPSM_ADDR_PHY: rdata_d = {13'h0000, eflag_q, energy_pd_q, gen_pd_q};
					default: rdata_d = 16'h0000;
				endcase
			end
		end

		if (wr_ok) begin
			case (bus.bus_addr)
				`EPSM_ADDR_CTRL: begin
					pin_en_d = bus.bus_wdata[`EPSM_CTRL_PIN_EN];
					pulse_sel_d = bus.bus_wdata[`EPSM_CTRL_PULSE_SEL];
					energy_en_d = bus.bus_wdata[`EPSM_CTRL_ENERGY_EN];
					frame_en_d = bus.bus_wdata[`EPSM_CTRL_FRAME_EN];
					wus_d = bus.bus_wdata[`EPSM_CTRL_WUS_HI:`EPSM_CTRL_WUS_LO];
					case (bus.bus_wdata[`EPSM_CTRL_MODE_HI:`EPSM_CTRL_MODE_LO])
						EPSM_D1: begin
							pstate_d = EPSM_D1; // RULE_06
							ready_d = 1'b0; // RULE_02
						end
						EPSM_D2: begin
							pstate_d = EPSM_D2; // RULE_11
							ready_d = 1'b0; // RULE_02
						end
						default: pstate_d = pstate_q;
					endcase
				end
				`EPSM_ADDR_INTERRUPT_STATUS_REGISTER: begin
					if (bus.bus_wdata[`EPSM_INT_WAKE]) begin
						int_d = 1'b0;
					end
				end
				`EPSM_ADDR_PHY: begin
					gen_pd_d = bus.bus_wdata[`EPSM_PHY_GEN_PD];
					energy_pd_d = bus.bus_wdata[`EPSM_PHY_ENERGY_PD];
					if (bus.bus_wdata[`EPSM_PHY_ENERGY_FLAG]) begin
						eflag_d = 1'b0;
					end
				end
				default: armed_d = armed_d;
			endcase
		end

		// wake write: back to D0, ready comes later, writes need a fresh read
		if (wake_wr) begin
			pstate_d = EPSM_D0; // RULE_05
			ready_d = 1'b0;
			armed_d = 1'b0; // RULE_04
			rdy_cnt_d = 16'h0000;
		end else if (pstate_q == EPSM_D0 && !ready_q) begin
			rdy_cnt_d = rdy_cnt_q + 16'h0001;
			if (rdy_cnt_q == 16'(READY_CYC - 1)) begin
				ready_d = 1'b1; // RULE_22 RULE_23
			end
		end

		// detection sets the source over any write in the same cycle
		if (pstate_q == EPSM_D1 && wake_frame_hit) begin
			wus_d = `EPSM_WUS_FRAME; // RULE_08
		end
		if (pstate_q == EPSM_D2 && energy_s2_q) begin
			wus_d = `EPSM_WUS_ENERGY; // RULE_13
		end
		if (cond) begin
			int_d = 1'b1; // RULE_10 RULE_17
		end

		if (energy_pd_q && energy_s2_q && !energy_prev_q) begin
			eflag_d = 1'b1; // RULE_21
		end
		phy_rst_d = gen_pd_q && !gen_pd_d; // RULE_20
		pin_cond_d = pin_cond;
		pme_d = pin_cond && (!pulse_sel_q || pulse_on); // RULE_18 RULE_19
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pstate_q <= EPSM_D0;
			ready_q <= 1'b1;
			armed_q <= 1'b0;
			pin_en_q <= 1'b0;
			pulse_sel_q <= 1'b0;
			energy_en_q <= 1'b0;
			frame_en_q <= 1'b0;
			wus_q <= `EPSM_WUS_NONE;
			int_q <= 1'b0;
			gen_pd_q <= 1'b0;
			energy_pd_q <= 1'b0;
			eflag_q <= 1'b0;
			phy_rst_q <= 1'b0;
			rdy_cnt_q <= 16'h0000;
			rdata_q <= `EPSM_RDATA_RST;
			rvalid_q <= 1'b0;
			pme_q <= 1'b0;
			pin_cond_q <= 1'b0;
			energy_s1_q <= 1'b0;
			energy_s2_q <= 1'b0;
			energy_prev_q <= 1'b0;
		end else if (ce) begin
			pstate_q <= pstate_d;
			ready_q <= ready_d;
			armed_q <= armed_d;
			pin_en_q <= pin_en_d;
			pulse_sel_q <= pulse_sel_d;
			energy_en_q <= energy_en_d;
			frame_en_q <= frame_en_d;
			wus_q <= wus_d;
			int_q <= int_d;
			gen_pd_q <= gen_pd_d;
			energy_pd_q <= energy_pd_d;
			eflag_q <= eflag_d;
			phy_rst_q <= phy_rst_d;
			rdy_cnt_q <= rdy_cnt_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			pme_q <= pme_d;
			pin_cond_q <= pin_cond_d;
			energy_s1_q <= line_energy_present;
			energy_s2_q <= energy_s1_q;
			energy_prev_q <= energy_s2_q;
		end
	end

	assign bus.bus_rdata = rdata_q;
	assign bus.bus_rvalid = rvalid_q;
	assign bus.pme = pme_q;
	assign bus.irq = int_q; // RULE_10
	assign power_state = pstate_q;
	assign mac_clk_en = (pstate_q == EPSM_D0); // RULE_07 RULE_12
	assign host_clk_en = (pstate_q == EPSM_D0); // RULE_07 RULE_12
	assign int_clk_en = (pstate_q != EPSM_D2); // RULE_07 RULE_12
	assign rx_pm_en = (pstate_q != EPSM_D2); // RULE_07
	assign phy_power_off = gen_pd_q || (energy_pd_q && !energy_s2_q); // RULE_20 RULE_21
	assign phy_reset = phy_rst_q; // RULE_20
endmodule // epsm_device

// ==== src/epsm_host.sv ====
// epsm_host: host end that sequences sleep entry and wake-up of the power state manager
// assumes: device on epsm_if.host; one command at a time from the user port
`timescale 1ns/10ps
`include "epsm_regs.svh"
module epsm_host (
	input  wire logic           clk,         // system clock
	input  wire logic           sys_rst,     // async reset, active high
	input  wire logic           ce,          // clock enable
	epsm_if.host                bus,         // host bus to the device
	input  wire logic           cmd_valid,   // command request
	input  epsm_pkg::epsm_op_t  cmd_op,      // sleep D1, sleep D2 or wake
	input  wire logic [3:0]     cfg_enables, // frame, energy, pulse select, pin enables
	output logic                cmd_ready,   // idle, command taken
	output logic                cmd_done,    // one-cycle completion pulse
	output logic [15:0]         ctrl_seen    // last control register read
);
	import epsm_pkg::*;

	epsm_hstate_t st_q, st_d;
	logic        rd_q, rd_d;
	logic        wr_q, wr_d;
	logic [3:0]  addr_q, addr_d;
	logic [15:0] wdata_q, wdata_d;
	logic [3:0]  cfg_q, cfg_d;
	logic        was_d2_q, was_d2_d;
	logic [15:0] seen_q, seen_d;

	always_comb begin
		st_d = st_q;
		rd_d = 1'b0;
		wr_d = 1'b0;
		addr_d = addr_q;
		wdata_d = wdata_q;
		cfg_d = cfg_q;
		was_d2_d = was_d2_q;
		seen_d = seen_q;
		cmd_ready = 1'b0;
		cmd_done = 1'b0;
		case (st_q)
			EPSM_HS_INIT_RD: begin
				rd_d = 1'b1; // RULE_04
				addr_d = `EPSM_ADDR_CTRL;
				st_d = EPSM_HS_INIT_WAIT;
			end
			EPSM_HS_INIT_WAIT: begin
				if (bus.bus_rvalid) begin
					seen_d = bus.bus_rdata;
					st_d = EPSM_HS_IDLE;
				end
			end
			EPSM_HS_IDLE: begin
				cmd_ready = 1'b1;
				if (cmd_valid) begin
					cfg_d = cfg_enables;
					case (cmd_op)
						EPSM_OP_SLEEP_D1: st_d = EPSM_HS_D1_WR;
						EPSM_OP_SLEEP_D2: st_d = EPSM_HS_D2_PHY;
						EPSM_OP_WAKE: st_d = EPSM_HS_WAKE_WR;
						default: st_d = EPSM_HS_IDLE;
					endcase
				end
			end
			EPSM_HS_D1_WR: begin
				wr_d = 1'b1;
				addr_d = `EPSM_ADDR_CTRL;
				wdata_d = {2'h0, EPSM_D1, 7'h00, cfg_q, 1'b0};
				st_d = EPSM_HS_DONE;
			end
			EPSM_HS_D2_PHY: begin
				wr_d = 1'b1; // RULE_11
				addr_d = `EPSM_ADDR_PHY;
				wdata_d = 16'h0000;
				wdata_d[`EPSM_PHY_ENERGY_PD] = 1'b1;
				st_d = EPSM_HS_D2_WR;
			end
			EPSM_HS_D2_WR: begin
				wr_d = 1'b1; // RULE_11
				addr_d = `EPSM_ADDR_CTRL;
				wdata_d = {2'h0, EPSM_D2, 7'h00, cfg_q, 1'b0};
				was_d2_d = 1'b1;
				st_d = EPSM_HS_DONE;
			end
			EPSM_HS_WAKE_WR: begin
				wr_d = 1'b1; // RULE_03
				addr_d = `EPSM_ADDR_WAKE_TEST;
				wdata_d = 16'h0000;
				st_d = EPSM_HS_POLL_RD;
			end
			EPSM_HS_POLL_RD: begin
				rd_d = 1'b1; // RULE_01
				addr_d = `EPSM_ADDR_CTRL;
				st_d = EPSM_HS_POLL_WAIT;
			end
			EPSM_HS_POLL_WAIT: begin
				if (bus.bus_rvalid) begin
					seen_d = bus.bus_rdata;
					if (!bus.bus_rdata[`EPSM_CTRL_READY]) begin
						st_d = EPSM_HS_POLL_RD;
					end else if (was_d2_q) begin
						st_d = EPSM_HS_PHY_CLR; // RULE_15
					end else begin
						st_d = EPSM_HS_WUS_CLR; // RULE_16
					end
				end
			end
			EPSM_HS_PHY_CLR: begin
				wr_d = 1'b1; // RULE_15
				addr_d = `EPSM_ADDR_PHY;
				wdata_d = 16'h0000;
				was_d2_d = 1'b0;
				st_d = EPSM_HS_WUS_CLR;
			end
			EPSM_HS_WUS_CLR: begin
				wr_d = 1'b1; // RULE_16
				addr_d = `EPSM_ADDR_CTRL;
				wdata_d = {2'h0, EPSM_D0, 7'h00, cfg_q, 1'b0};
				st_d = EPSM_HS_DONE;
			end
			EPSM_HS_DONE: begin
				cmd_done = 1'b1;
				st_d = EPSM_HS_IDLE;
			end
			default: st_d = EPSM_HS_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= EPSM_HS_INIT_RD;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= 4'h0;
			wdata_q <= 16'h0000;
			cfg_q <= 4'h0;
			was_d2_q <= 1'b0;
			seen_q <= 16'h0000;
		end else if (ce) begin
			st_q <= st_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			cfg_q <= cfg_d;
			was_d2_q <= was_d2_d;
			seen_q <= seen_d;
		end
	end

	assign bus.bus_rd = rd_q;
	assign bus.bus_wr = wr_q;
	assign bus.bus_addr = addr_q;
	assign bus.bus_wdata = wdata_q;
	assign ctrl_seen = seen_q;
endmodule // epsm_host

// ==== src/epsm_if.sv ====
// epsm_if: host bus and wake pin between the host and the power state manager
// assumes: both ends share clk; rd and wr are one-cycle strobes
`timescale 1ns/10ps
interface epsm_if;
	logic        bus_rd;
	logic        bus_wr;
	logic [3:0]  bus_addr;
	logic [15:0] bus_wdata;
	logic [15:0] bus_rdata;
	logic        bus_rvalid;
	logic        pme;
	logic        irq;

	modport dev (input bus_rd, input bus_wr, input bus_addr, input bus_wdata,
		output bus_rdata, output bus_rvalid, output pme, output irq);
	modport host (output bus_rd, output bus_wr, output bus_addr, output bus_wdata,
		input bus_rdata, input bus_rvalid, input pme, input irq);
endinterface

// ==== src/epsm_pkg.sv ====
// epsm_pkg: types of the power state manager
// assumes: no other package is needed
package epsm_pkg;
	typedef enum logic [1:0] {
		EPSM_D0 = 2'b00,
		EPSM_D1 = 2'b01,
		EPSM_D2 = 2'b10
	} epsm_pstate_t;

	typedef enum logic [1:0] {
		EPSM_OP_SLEEP_D1 = 2'b00,
		EPSM_OP_SLEEP_D2 = 2'b01,
		EPSM_OP_WAKE     = 2'b10
	} epsm_op_t;

	typedef enum logic [3:0] {
		EPSM_HS_INIT_RD   = 4'b0000,
		EPSM_HS_INIT_WAIT = 4'b0001,
		EPSM_HS_IDLE      = 4'b0010,
		EPSM_HS_D1_WR     = 4'b0011,
		EPSM_HS_D2_PHY    = 4'b0100,
		EPSM_HS_D2_WR     = 4'b0101,
		EPSM_HS_WAKE_WR   = 4'b0110,
		EPSM_HS_POLL_RD   = 4'b0111,
		EPSM_HS_POLL_WAIT = 4'b1000,
		EPSM_HS_PHY_CLR   = 4'b1001,
		EPSM_HS_WUS_CLR   = 4'b1010,
		EPSM_HS_DONE      = 4'b1011
	} epsm_hstate_t;
endpackage

// ==== src/epsm_pulse_timer.sv ====
// epsm_pulse_timer: one-shot of CYC cycles, cut short when hold drops
// assumes: start and hold come from logic on clk
`timescale 1ns/10ps
module epsm_pulse_timer #(
	parameter int unsigned CYC = 1
) (
	input  wire logic clk,     // system clock
	input  wire logic sys_rst, // async reset, active high
	input  wire logic ce,      // clock enable
	input  wire logic start,   // begin a pulse
	input  wire logic hold,    // pulse survives only while high
	output logic      active   // pulse running
);
	localparam int W = $clog2(CYC + 1);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (start) begin
			cnt_d = W'(CYC);
		end else if (!hold) begin
			cnt_d = '0;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - W'(1);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else if (ce) begin
			cnt_q <= cnt_d;
		end
	end

	assign active = (cnt_q != '0);
endmodule // epsm_pulse_timer

// ==== src/epsm_regs.svh ====
// epsm_regs.svh: register offsets, field positions, reset values and timing counts
// assumes: included by bare name into the device, host, assertions and bench files
`ifndef EPSM_REGS_SVH
`define EPSM_REGS_SVH

// register offsets on the 4-bit host address
`define EPSM_ADDR_CTRL       4'h0
`define EPSM_ADDR_WAKE_TEST  4'h1
`define EPSM_ADDR_INTERRUPT_STATUS_REGISTER    4'h2
`define EPSM_ADDR_PHY        4'h3

// power_mgmt_control fields
`define EPSM_CTRL_READY      0
`define EPSM_CTRL_PIN_EN     1
`define EPSM_CTRL_PULSE_SEL  2
`define EPSM_CTRL_ENERGY_EN  3
`define EPSM_CTRL_FRAME_EN   4
`define EPSM_CTRL_WUS_LO     5
`define EPSM_CTRL_WUS_HI     6
`define EPSM_CTRL_MODE_LO    12
`define EPSM_CTRL_MODE_HI    13

// interrupt_status_register and phy control fields
`define EPSM_INT_WAKE        0
`define EPSM_PHY_GEN_PD      0
`define EPSM_PHY_ENERGY_PD   1
`define EPSM_PHY_ENERGY_FLAG 2

// wakeup_source_status codes
`define EPSM_WUS_NONE        2'h0
`define EPSM_WUS_ENERGY      2'h1
`define EPSM_WUS_FRAME       2'h2

// reset values
`define EPSM_CTRL_RST        16'h0001
`define EPSM_RDATA_RST       16'h0000

// timing
`define EPSM_CLK_MHZ         25
`define EPSM_READY_US        2000
`define EPSM_PULSE_MS        50
`define EPSM_READY_CYC       (`EPSM_READY_US * `EPSM_CLK_MHZ)
`define EPSM_PULSE_CYC       (`EPSM_PULSE_MS * 1000 * `EPSM_CLK_MHZ)

`endif

// ==== verif/epsm_assertions.sv ====
// epsm_assertions: timing checks on the bus and wake pin joining host and device
// assumes: instantiated by the bench beside that interface; one clock, reset active high
`timescale 1ns/10ps
`include "epsm_regs.svh"
module epsm_assertions #(
	parameter int READY_CYC = 8,
	parameter int PULSE_CYC = 6
) (
	input wire logic        clk,        // system clock
	input wire logic        sys_rst,    // async reset, active high
	input wire logic        bus_rd,     // read strobe
	input wire logic        bus_wr,     // write strobe
	input wire logic [3:0]  bus_addr,   // register address
	input wire logic [15:0] bus_wdata,  // write data
	input wire logic [15:0] bus_rdata,  // read data
	input wire logic        bus_rvalid, // read answer
	input wire logic        pme,        // wake pin
	input wire logic        irq         // wake interrupt status
);
	localparam int RDY_MAX = READY_CYC + 8;
	logic        sleep_q, sleep_d, rdy_q, rdy_d, ed_q, ed_d, pulse_q, pulse_d;
	logic [1:0]  mode_q, mode_d;
	logic [3:0]  raddr_q, raddr_d;
	logic [15:0] run_q, run_d;
	logic        wr_ctrl, wake;
	assign wr_ctrl = bus_wr && bus_addr == `EPSM_ADDR_CTRL && rdy_q;
	assign wake = bus_wr && bus_addr == `EPSM_ADDR_WAKE_TEST && sleep_q;
	// mirror of what the device has accepted, as seen on the bus
	always_comb begin
		sleep_d = sleep_q;
		rdy_d = rdy_q;
		mode_d = mode_q;
		ed_d = ed_q;
		pulse_d = pulse_q;
		raddr_d = bus_rd ? bus_addr : raddr_q;
		run_d = pme ? run_q + 16'h1 : 16'h0;
		if (wr_ctrl) begin
			pulse_d = bus_wdata[`EPSM_CTRL_PULSE_SEL];
		end
		if (wr_ctrl && (bus_wdata[13:12] == 2'h1 || bus_wdata[13:12] == 2'h2)) begin
			sleep_d = 1'b1;
			rdy_d = 1'b0;
			mode_d = bus_wdata[13:12];
		end
		if (rdy_q && bus_wr && bus_addr == `EPSM_ADDR_PHY) begin
			ed_d = bus_wdata[`EPSM_PHY_ENERGY_PD];
		end
		if (wake) begin
			sleep_d = 1'b0;
			rdy_d = 1'b0;
			mode_d = 2'h0;
		end
		if (bus_rvalid && raddr_q == `EPSM_ADDR_CTRL && bus_rdata[0] && !sleep_q) begin
			rdy_d = 1'b1;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sleep_q <= 1'b0;
			rdy_q <= 1'b0;
			mode_q <= 2'h0;
			ed_q <= 1'b0;
			pulse_q <= 1'b0;
			raddr_q <= 4'h0;
			run_q <= 16'h0;
		end else begin
			sleep_q <= sleep_d;
			rdy_q <= rdy_d;
			mode_q <= mode_d;
			ed_q <= ed_d;
			pulse_q <= pulse_d;
			raddr_q <= raddr_d;
			run_q <= run_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_wake_wr;
		bus_wr && bus_addr == `EPSM_ADDR_WAKE_TEST && sleep_q;
	endsequence
	sequence s_ready_rd;
		bus_rvalid && raddr_q == `EPSM_ADDR_CTRL && bus_rdata[`EPSM_CTRL_READY];
	endsequence
	a_rd_answer: assert property (bus_rd |=> bus_rvalid)
		else $error("read strobe got no answer");
	a_no_stray_answer: assert property (!bus_rd |=> !bus_rvalid)
		else $error("answer without a read strobe");
	a_mode_reads: assert property (bus_rvalid && raddr_q == `EPSM_ADDR_CTRL |->
		bus_rdata[13:12] == mode_q) else $error("power state field wrong");
	a_ready_within: assert property (s_wake_wr |-> ##[1:RDY_MAX] s_ready_rd)
		else $error("ready not seen after wake write");
	a_pulse_len: assert property (pme && pulse_q |-> run_q < PULSE_CYC)
		else $error("wake pulse too long");
	a_pin_drop: assert property (wr_ctrl && !sleep_q && bus_wdata[6:5] == 2'h0 |-> ##2 !pme)
		else $error("wake pin stays after source clear");
	a_pin_has_irq: assert property ($rose(pme) |-> irq)
		else $error("wake pin without interrupt status");
	a_wr_after_ready: assert property (bus_wr && bus_addr != `EPSM_ADDR_WAKE_TEST |-> rdy_q)
		else $error("write before ready was read");
	a_rd_ctrl_only: assert property (bus_rd && !rdy_q |-> bus_addr == `EPSM_ADDR_CTRL)
		else $error("read of other register while not ready");
	a_d2_order: assert property (bus_wr && bus_addr == `EPSM_ADDR_CTRL &&
		bus_wdata[13:12] == 2'h2 |-> ed_q) else $error("D2 before energy powerdown");
endmodule // epsm_assertions

// ==== verif/ethernet_power_state_manager_tb.sv ====
// ethernet_power_state_manager_tb: host and device joined, plus a device on a bench-driven bus
// assumes: design files compiled first; small ready and pulse counts
`timescale 1ns/10ps
`include "epsm_regs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module ethernet_power_state_manager_tb;
	import epsm_pkg::*;
	localparam int RDY = 8;
	localparam int PUL = 6;
	logic         clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic         ce = 1'b1;
	logic         cmd_valid = 1'b0;
	epsm_op_t     cmd_op = EPSM_OP_SLEEP_D1;
	logic [3:0]   cfg_enables = 4'h0;
	logic         wake_frame_hit = 1'b0;
	logic         line_energy_present = 1'b0;
	logic         cmd_ready, cmd_done, mac_a, host_a, int_a, rxpm_a, off_b, prst_b;
	logic [15:0]  ctrl_seen;
	epsm_pstate_t state_a, state_b;
	int           miscompares = 0;
	int           check_count = 0;
	epsm_if bus_a();
	epsm_if bus_b();
	always #20 clk = ~clk;
	epsm_device #(.READY_CYC(RDY), .PULSE_CYC(PUL)) i_epsm_device (.clk(clk), .sys_rst(sys_rst),
		.ce(ce), .bus(bus_a), .wake_frame_hit(wake_frame_hit),
		.line_energy_present(line_energy_present), .mac_clk_en(mac_a), .host_clk_en(host_a),
		.int_clk_en(int_a), .rx_pm_en(rxpm_a), .phy_power_off(), .phy_reset(),
		.power_state(state_a));
	epsm_host i_epsm_host (.clk(clk), .sys_rst(sys_rst), .ce(ce), .bus(bus_a),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cfg_enables(cfg_enables),
		.cmd_ready(cmd_ready), .cmd_done(cmd_done), .ctrl_seen(ctrl_seen));
	// second device driven straight from the bench to break the host's rules
	epsm_device #(.READY_CYC(RDY), .PULSE_CYC(PUL)) i_epsm_device_b (.clk(clk),
		.sys_rst(sys_rst), .ce(ce), .bus(bus_b), .wake_frame_hit(wake_frame_hit),
		.line_energy_present(line_energy_present), .mac_clk_en(), .host_clk_en(),
		.int_clk_en(), .rx_pm_en(), .phy_power_off(off_b), .phy_reset(prst_b),
		.power_state(state_b));
	epsm_assertions #(.READY_CYC(RDY), .PULSE_CYC(PUL)) i_epsm_assertions (.clk(clk),
		.sys_rst(sys_rst), .bus_rd(bus_a.bus_rd), .bus_wr(bus_a.bus_wr),
		.bus_addr(bus_a.bus_addr), .bus_wdata(bus_a.bus_wdata), .bus_rdata(bus_a.bus_rdata),
		.bus_rvalid(bus_a.bus_rvalid), .pme(bus_a.pme), .irq(bus_a.irq));

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		bus_b.bus_rd <= 1'b1;
		bus_b.bus_addr <= a;
		@(posedge clk);
		bus_b.bus_rd <= 1'b0;
		#1;
		`CHK("read answer", 1'b1, bus_b.bus_rvalid)
		d = bus_b.bus_rdata;
	endtask

	task automatic rd_exp(input logic [3:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		`CHK("read data", e, d)
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus_b.bus_wr <= 1'b1;
		bus_b.bus_addr <= a;
		bus_b.bus_wdata <= d;
		@(posedge clk);
		bus_b.bus_wr <= 1'b0;
	endtask

	// hand one command to the host and wait for its completion pulse
	task automatic run_cmd(input epsm_op_t op, input logic [3:0] en);
		int i;
		i = 0;
		while (cmd_ready !== 1'b1 && i < 100) begin
			@(negedge clk);
			i++;
		end
		`CHK("command ready", 1'b1, cmd_ready)
		if (cmd_ready !== 1'b1) begin
			wrap_up();
		end
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cfg_enables <= en;
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(negedge clk);
		i = 0;
		while (cmd_done !== 1'b1 && i < 200) begin
			@(negedge clk);
			i++;
		end
		`CHK("command done", 1'b1, cmd_done)
		if (cmd_done !== 1'b1) begin
			wrap_up();
		end
	endtask

	task automatic frame_hit();
		@(posedge clk);
		wake_frame_hit <= 1'b1;
		@(posedge clk);
		wake_frame_hit <= 1'b0;
		repeat (4) @(negedge clk);
	endtask

	initial begin
		int i;
		int n;
		logic [15:0] d;
		bus_b.bus_rd <= 1'b0;
		bus_b.bus_wr <= 1'b0;
		bus_b.bus_addr <= 4'h0;
		bus_b.bus_wdata <= 16'h0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		wr(`EPSM_ADDR_CTRL, 16'h0002);
		rd_exp(`EPSM_ADDR_CTRL, 16'h0001);
		wr(`EPSM_ADDR_CTRL, 16'h0002);
		rd_exp(`EPSM_ADDR_CTRL, 16'h0003);
		wr(`EPSM_ADDR_PHY, 16'h0001);
		@(negedge clk);
		`CHK("phy off", 1'b1, off_b)
		wr(`EPSM_ADDR_PHY, 16'h0000);
		i = 0;
		while (prst_b !== 1'b1 && i < 4) begin
			@(negedge clk);
			i++;
		end
		`CHK("phy reset", 1'b1, prst_b)
		if (prst_b !== 1'b1) begin
			wrap_up();
		end
		wr(`EPSM_ADDR_PHY, 16'h0002);
		@(negedge clk);
		`CHK("phy off", 1'b1, off_b)
		@(posedge clk);
		line_energy_present <= 1'b1;
		repeat (4) @(negedge clk);
		`CHK("phy off", 1'b0, off_b)
		rd_exp(`EPSM_ADDR_PHY, 16'h0006);
		wr(`EPSM_ADDR_PHY, 16'h0004);
		rd_exp(`EPSM_ADDR_PHY, 16'h0000);
		wr(`EPSM_ADDR_CTRL, 16'h1000);
		@(negedge clk);
		`CHK("state", EPSM_D1, state_b)
		rd_exp(`EPSM_ADDR_CTRL, 16'h1000);
		wr(`EPSM_ADDR_CTRL, 16'h0002);
		rd_exp(`EPSM_ADDR_CTRL, 16'h1000);
		wr(`EPSM_ADDR_WAKE_TEST, 16'ha5c3);
		@(negedge clk);
		`CHK("state", EPSM_D0, state_b)
		wr(`EPSM_ADDR_CTRL, 16'h0002);
		d = 16'h0;
		i = 0;
		while (d[0] !== 1'b1 && i < RDY) begin
			rd(`EPSM_ADDR_CTRL, d);
			i++;
		end
		`CHK("ready read", 16'h0001, d)
		if (d[0] !== 1'b1) begin
			wrap_up();
		end
		// D2 with level pin, then sticky interrupt status and its clear
		wr(`EPSM_ADDR_PHY, 16'h0002);
		wr(`EPSM_ADDR_CTRL, 16'h200a);
		rd_exp(`EPSM_ADDR_INTERRUPT_STATUS_REGISTER, 16'h0000);
		`CHK("wake pin b", 1'b1, bus_b.pme)
		`CHK("interrupt b", 1'b1, bus_b.irq)
		wr(`EPSM_ADDR_WAKE_TEST, 16'h0000);
		repeat (RDY + 2) @(posedge clk);
		rd_exp(`EPSM_ADDR_CTRL, 16'h002b);
		wr(`EPSM_ADDR_INTERRUPT_STATUS_REGISTER, 16'h0001);
		rd_exp(`EPSM_ADDR_INTERRUPT_STATUS_REGISTER, 16'h0001);
		wr(`EPSM_ADDR_CTRL, 16'h000a);
		wr(`EPSM_ADDR_INTERRUPT_STATUS_REGISTER, 16'h0001);
		rd_exp(`EPSM_ADDR_INTERRUPT_STATUS_REGISTER, 16'h0000);
		`CHK("wake pin b", 1'b0, bus_b.pme)
		`CHK("interrupt b", 1'b0, bus_b.irq)
		run_cmd(EPSM_OP_SLEEP_D1, 4'h9);
		@(negedge clk);
		`CHK("state", EPSM_D1, state_a)
		`CHK("clock enables", 4'h3, {mac_a, host_a, int_a, rxpm_a})
		frame_hit();
		`CHK("interrupt", 1'b1, bus_a.irq)
		`CHK("wake pin", 1'b1, bus_a.pme)
		run_cmd(EPSM_OP_WAKE, 4'h9);
		`CHK("state", EPSM_D0, state_a)
		`CHK("wake source", 2'h2, ctrl_seen[6:5])
		`CHK("ready", 1'b1, ctrl_seen[0])
		repeat (3) @(negedge clk);
		`CHK("wake pin", 1'b0, bus_a.pme)
		`CHK("interrupt", 1'b1, bus_a.irq)
		run_cmd(EPSM_OP_SLEEP_D1, 4'h8);
		frame_hit();
		`CHK("wake pin", 1'b0, bus_a.pme)
		run_cmd(EPSM_OP_WAKE, 4'h8);
		run_cmd(EPSM_OP_SLEEP_D2, 4'h7);
		@(negedge clk);
		`CHK("state", EPSM_D2, state_a)
		`CHK("clock enables", 4'h0, {mac_a, host_a, int_a, rxpm_a})
		n = 0;
		repeat (30) begin
			@(negedge clk);
			n += (bus_a.pme === 1'b1) ? 1 : 0;
		end
		`CHK("pulse length", PUL, n)
		run_cmd(EPSM_OP_WAKE, 4'h7);
		`CHK("wake source", 2'h1, ctrl_seen[6:5])
		`CHK("state", EPSM_D0, state_a)
		wrap_up();
	end
endmodule // ethernet_power_state_manager_tb
